// [verilog/smrd_pkg.sv]
// constants and register map of the supply monitor reset logic
// assumes a 50 MHz aclk and abstract comparator inputs from the analog side
// Summary of operation
// - wait start-up delay after power-on reset
// - add 64 ms delay when timer enabled
// - enable bit selects timer or bypass
// - two-bit field selects brown-out trip level
// - brown-out active by default, config disables
// - soft enable bit controls when config disabled
// - brown-out drops reset and sets flag bit1
// - enabled detector trip sets interrupt flag
// - four-bit limit field picks one of 16
// - limit 1111 uses external detect input
// - other codes pick internal trip ranges
// - detector runs only while enable set
// - crossing in direction raises interrupt, sets flag
// - external mode trips at 1.2V crossing
// - bit 7 selects rising or falling trigger
// - set: at or above; clear: at or below
// - idle-stop bit suspends detector in idle
// - no flag while reference unstable
package smrd_pkg;
	// byte offsets on the register bus
	localparam logic [3:0] OFF_RST_CTRL   = 4'h0;
	localparam logic [3:0] OFF_VD_CTRL    = 4'h4;
	localparam logic [3:0] OFF_IRQ_STATUS = 4'h8;
	localparam logic [3:0] OFF_IRQ_MASK   = 4'hC;
	// reset control register fields
	localparam int RC_SOFT_EN_BIT = 0;
	localparam int RC_BOR_FLAG_BIT = 1;
	localparam int RC_STARTED_BIT = 2;
	// detector control fields
	localparam int VD_EN_BIT     = 15;
	localparam int VD_IDLE_BIT   = 13;
	localparam int VD_DIR_BIT    = 7;
	localparam int VD_BGST_BIT   = 6;
	localparam int VD_IRST_BIT   = 5;
	localparam logic [15:0] VD_WMASK = 16'hA08F;
	localparam logic [15:0] VD_RESET = 16'h0000;
	localparam logic [3:0]  VD_LIMIT_EXT = 4'hF;
	// status bits
	localparam int ST_BOR_BIT = 0;
	localparam int ST_VD_BIT  = 1;
	localparam int ST_W       = 2;
	// timing
	localparam int CLK_HZ          = 50_000_000;
	localparam int POWER_UP_DELAY_TIMER_MS         = 64;
	localparam int POWER_UP_DELAY_TIMER_CYCLES     = POWER_UP_DELAY_TIMER_MS * (CLK_HZ / 1000);
	localparam int STARTUP_US      = 10;
	localparam int STARTUP_CYCLES  = STARTUP_US * (CLK_HZ / 1_000_000);
	// power-up sequence states
	typedef enum logic [1:0] {SEQ_STARTUP, SEQ_POWER_UP_DELAY_TIMER, SEQ_RUN} smrd_seq_t;
endpackage

// [verilog/smrd_sync.sv]
// two-flop synchroniser for asynchronous level inputs
// assumes inputs come from the analog side with no relation to aclk
`timescale 1ns/1ps
`default_nettype none
module smrd_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// level in and out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule
`default_nettype wire

// [verilog/smrd_top.sv]
// supply monitor: start-up sequencing, brown-out reset and voltage detector
// assumes analog comparators deliver level outputs; AXI4-Lite register access
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module smrd_top #(
	parameter int STARTUP_CNT = smrd_pkg::STARTUP_CYCLES,
	parameter int POWER_UP_DELAY_TIMER_CNT    = smrd_pkg::POWER_UP_DELAY_TIMER_CYCLES
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// configuration word
	input  wire logic        power_up_delay_enable,
	input  wire logic [1:0]  brownout_level_select,
	input  wire logic [1:0]  brownout_config_enable,
	// analog side
	input  wire logic        supply_below_bor,
	input  wire logic [14:0] supply_above_tap,
	input  wire logic        ext_detect_above,
	input  wire logic        bandgap_stable,
	input  wire logic        ref_stable,
	input  wire logic        device_idle,
	output logic [1:0]       bor_level_out,
	output logic [3:0]       detect_limit_out,
	output logic             detector_on,
	// reset outputs
	output logic             run_enable,
	output logic             brownout_reset,
	// interrupt
	output logic             irq,
	// axi4-lite write address
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	localparam logic [1:0] RESP_OK  = 2'b00;
	localparam logic [1:0] RESP_ERR = 2'b10;

	// synchronised analog levels
	logic [19:0] async_in;
	logic [19:0] sync_q;
	assign async_in = {supply_below_bor, supply_above_tap, ext_detect_above,
	                   bandgap_stable, ref_stable, device_idle};
	smrd_sync #(.W(20)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (async_in),
		.q       (sync_q)
	);
	wire        below_bor_s = sync_q[19];
	wire [14:0] tap_s       = sync_q[18:4];
	wire        ext_s       = sync_q[3];
	wire        bg_s        = sync_q[2];
	wire        ref_s       = sync_q[1];
	wire        idle_s      = sync_q[0];

	// registers
	logic        soft_en_r;
	logic        bor_flag_r;
	logic [15:0] vd_ctrl_r;
	logic [1:0]  status_r;
	logic [1:0]  mask_r;
	logic        armed_r;

	// power-up sequencing
	smrd_pkg::smrd_seq_t seq_r;
	smrd_pkg::smrd_seq_t seq_nxt;
	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic        power_up_delay_timer_en_r;

	always_comb begin
		seq_nxt = seq_r;
		cnt_nxt = cnt_r + 32'h1;
		unique case (seq_r)
			smrd_pkg::SEQ_STARTUP: begin
				if (cnt_r >= 32'(STARTUP_CNT - 1)) begin
					cnt_nxt = 32'h0;
					seq_nxt = power_up_delay_timer_en_r ? smrd_pkg::SEQ_POWER_UP_DELAY_TIMER : smrd_pkg::SEQ_RUN;
				end
			end
			smrd_pkg::SEQ_POWER_UP_DELAY_TIMER: begin
				if (cnt_r >= 32'(POWER_UP_DELAY_TIMER_CNT - 1)) begin
					cnt_nxt = 32'h0;
					seq_nxt = smrd_pkg::SEQ_RUN;
				end
			end
			smrd_pkg::SEQ_RUN: begin
				cnt_nxt = 32'h0;
			end
		endcase
	end

	// brown-out: restart the sequence while the supply is low
	wire bor_active = (brownout_config_enable != 2'b00) || soft_en_r;
	wire bor_event  = bor_active && below_bor_s;
	assign bor_level_out = brownout_level_select;

	always_ff @(posedge aclk) begin
		if (!aresetn || bor_event) begin
			seq_r <= smrd_pkg::SEQ_STARTUP;
			cnt_r <= 32'h0;
		end else begin
			seq_r <= seq_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// configuration captured after reset release, not at the async edge
	always_ff @(posedge aclk) begin
		if (seq_r == smrd_pkg::SEQ_STARTUP && cnt_r == 32'h0) begin
			power_up_delay_timer_en_r <= power_up_delay_enable;
		end
	end

	assign run_enable     = (seq_r == smrd_pkg::SEQ_RUN) && !bor_event;
	assign brownout_reset = bor_event;

	// voltage detector
	wire [3:0] limit   = vd_ctrl_r[3:0];
	wire       vd_en   = vd_ctrl_r[smrd_pkg::VD_EN_BIT];
	wire       vd_dir  = vd_ctrl_r[smrd_pkg::VD_DIR_BIT];
	wire       vd_idle = vd_ctrl_r[smrd_pkg::VD_IDLE_BIT];
	wire       ext_sel = (limit == smrd_pkg::VD_LIMIT_EXT);
	// top slot padded with the pin so every limit code indexes in range
	wire [15:0] cmp_all = {ext_s, tap_s};
	// comparator output picked by limit field; 1.2V reference is analog-side
	wire       above   = ext_sel ? ext_s : cmp_all[limit];
	wire       running = vd_en && !(vd_idle && idle_s);
	// tripped: at or above when rising, at or below when falling
	wire       tripped = vd_dir ? above : !above;
	wire       vd_event = running && ref_s && armed_r && tripped;
	assign detect_limit_out = limit;
	assign detector_on      = running;

	// arm once the comparator has seen the untripped side after enabling
	always_ff @(posedge aclk) begin
		if (!aresetn || !running) begin
			armed_r <= 1'b0;
		end else begin
			if (!tripped && ref_s) begin
				armed_r <= 1'b1;
			end else if (vd_event) begin
				armed_r <= 1'b0;
			end
		end
	end

	// axi4-lite slave: one write and one read outstanding
	logic        aw_got_r;
	logic        w_got_r;
	logic [3:0]  awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;

	assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
	wire aw_hs  = s_axi_awvalid && s_axi_awready;
	wire w_hs   = s_axi_wvalid && s_axi_wready;
	wire aw_now = aw_got_r || aw_hs;
	wire w_now  = w_got_r || w_hs;
	wire [3:0]  wa   = aw_got_r ? awaddr_r : s_axi_awaddr;
	wire [31:0] wd   = w_got_r ? wdata_r : s_axi_wdata;
	wire [3:0]  ws   = w_got_r ? wstrb_r : s_axi_wstrb;
	wire wr_do      = aw_now && w_now && !s_axi_bvalid;
	wire wr_rc      = wr_do && (wa == smrd_pkg::OFF_RST_CTRL);
	wire wr_vd      = wr_do && (wa == smrd_pkg::OFF_VD_CTRL);
	wire wr_mask    = wr_do && (wa == smrd_pkg::OFF_IRQ_MASK);
	wire wr_stat    = wr_do && (wa == smrd_pkg::OFF_IRQ_STATUS);
	wire wr_ok      = wr_rc || wr_vd || wr_mask || wr_stat;

	assign s_axi_arready = !s_axi_rvalid;
	wire rd_do    = s_axi_arvalid && s_axi_arready;
	wire rd_rc    = s_axi_araddr == smrd_pkg::OFF_RST_CTRL;
	wire rd_vd    = s_axi_araddr == smrd_pkg::OFF_VD_CTRL;
	wire rd_stat  = s_axi_araddr == smrd_pkg::OFF_IRQ_STATUS;
	wire rd_mask  = s_axi_araddr == smrd_pkg::OFF_IRQ_MASK;
	wire rd_ok    = rd_rc || rd_vd || rd_stat || rd_mask;

	// live status bits overlay the stored control bits
	wire [15:0] vd_view = (vd_ctrl_r & smrd_pkg::VD_WMASK)
	                    | (16'(bg_s) << smrd_pkg::VD_BGST_BIT)
	                    | (16'(ref_s) << smrd_pkg::VD_IRST_BIT);
	wire [31:0] rc_view = {29'h0, run_enable, bor_flag_r, soft_en_r};
	wire [31:0] rd_val  = rd_rc   ? rc_view :
	                      rd_vd   ? {16'h0, vd_view} :
	                      rd_stat ? {30'h0, status_r} :
	                      rd_mask ? {30'h0, mask_r} : 32'h0;

	// flags: hardware set wins over software clear
	wire clr_bor = wr_rc && ws[0] && !wd[smrd_pkg::RC_BOR_FLAG_BIT];
	wire [1:0] ev = {vd_event, bor_event};
	wire       stat_rd_clr = rd_do && rd_stat;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
			awaddr_r <= 4'h0;
			wdata_r  <= 32'h0;
			wstrb_r  <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OK;
		end else begin
			if (aw_hs) awaddr_r <= s_axi_awaddr;
			if (w_hs) wdata_r <= s_axi_wdata;
			if (w_hs) wstrb_r <= s_axi_wstrb;
			aw_got_r <= aw_now && !wr_do;
			w_got_r  <= w_now && !wr_do;
			if (wr_do) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? RESP_OK : RESP_ERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= RESP_OK;
		end else if (rd_do) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_val;
			s_axi_rresp  <= rd_ok ? RESP_OK : RESP_ERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// register file; bor flag survives the brown-out it records
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			soft_en_r  <= 1'b0;
			bor_flag_r <= 1'b0;
			vd_ctrl_r  <= smrd_pkg::VD_RESET;
			mask_r     <= 2'h0;
			status_r   <= 2'h0;
		end else begin
			if (wr_rc && ws[0]) soft_en_r <= wd[smrd_pkg::RC_SOFT_EN_BIT];
			if (bor_event) begin
				bor_flag_r <= 1'b1;
			end else if (clr_bor) begin
				bor_flag_r <= 1'b0;
			end
			if (wr_vd) begin
				if (ws[0]) vd_ctrl_r[7:0] <= wd[7:0] & smrd_pkg::VD_WMASK[7:0];
				if (ws[1]) vd_ctrl_r[15:8] <= wd[15:8] & smrd_pkg::VD_WMASK[15:8];
			end
			if (wr_mask && ws[0]) mask_r <= wd[1:0];
			status_r <= ev | (stat_rd_clr ? 2'h0 : status_r);
		end
	end

	// detector flag lives in status bit 1: sticky until the status read
	assign irq = |(status_r & mask_r);
endmodule
`default_nettype wire

// [dv/smrd_asserts.sv]
// assertions on the supply monitor top ports
// assumes one aclk domain and small start-up counts from the bench
`timescale 1ns/1ps
`default_nettype none
module smrd_asserts #(
	parameter int STARTUP_CNT = 4,
	parameter int POWER_UP_DELAY_TIMER_CNT    = 8
) (
	// watched ports
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       power_up_delay_enable,
	input wire logic [1:0] brownout_level_select,
	input wire logic [1:0] brownout_config_enable,
	input wire logic       supply_below_bor,
	input wire logic [1:0] bor_level_out,
	input wire logic       run_enable,
	input wire logic       brownout_reset,
	input wire logic       irq,
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_arvalid
);
	logic [31:0] cyc_r;
	logic        low_r;
	int          run_by;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// late bound holds only while the supply never dipped
	assign run_by = STARTUP_CNT + (power_up_delay_enable ? POWER_UP_DELAY_TIMER_CNT : 0) + 10;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cyc_r <= '0;
			low_r <= 1'b0;
		end else begin
			cyc_r <= cyc_r + 32'h1;
			low_r <= low_r | supply_below_bor;
		end
	end
	AST_START_MIN: assert property (run_enable |-> cyc_r >= STARTUP_CNT - 1)
		else $error("run too early");
	AST_POWER_UP_DELAY_TIMER_MIN: assert property (
		run_enable && power_up_delay_enable |-> cyc_r >= STARTUP_CNT + POWER_UP_DELAY_TIMER_CNT - 1)
		else $error("power-up delay cut short");
	AST_RUN_BY: assert property (!low_r && cyc_r == 32'(run_by) |-> run_enable)
		else $error("run not raised");
	AST_BOR_LVL: assert property (bor_level_out == brownout_level_select)
		else $error("level select not passed");
	AST_BOR_ON: assert property (
		(supply_below_bor && brownout_config_enable != 2'b00)[*3] |=> brownout_reset)
		else $error("brown-out reset missing");
	AST_BOR_CAUSE: assert property ((!supply_below_bor)[*3] |=> !brownout_reset)
		else $error("brown-out reset without cause");
	AST_BOR_RUN: assert property (brownout_reset |-> !run_enable)
		else $error("run during brown-out");
	AST_IRQ_HOLD: assert property (
		(irq && !s_axi_arvalid && !s_axi_awvalid)[*4] |=> irq)
		else $error("irq dropped without software");
	COV_RUN: cover property ($rose(run_enable));
	COV_BOR: cover property ($rose(brownout_reset));
	COV_IRQ: cover property ($rose(irq));
endmodule
`default_nettype wire

// [dv/test_supply_monitor_reset_detect.sv]
// bench for the supply monitor top, reset tests, register rows, then hand tests
// assumes the checker file is compiled first
`timescale 1ns/1ps
`default_nettype none
module test_supply_monitor_reset_detect;
	localparam int SC = 4;
	localparam int PC = 8;
	typedef struct packed {
		logic wr; logic [3:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;
	} smrd_row_t;
	logic        aclk, aresetn, power_up_delay_enable, supply_below_bor, ext_detect_above;
	logic        bandgap_stable, ref_stable, device_idle, detector_on, run_enable, irq;
	logic        brownout_reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready;
	logic [1:0]  brownout_level_select, brownout_config_enable, bor_level_out;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [3:0]  detect_limit_out, s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
	logic [14:0] supply_above_tap;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
	int          errors = 0;
	int          n_checks = 0;
	smrd_row_t   rows [9] = '{
		'{1'b0, 4'h4, 32'h0, 32'h60, 2'h0}, '{1'b0, 4'hC, 32'h0, 32'h0, 2'h0},
		'{1'b0, 4'h8, 32'h0, 32'h0, 2'h0}, '{1'b0, 4'h0, 32'h0, 32'h4, 2'h0},
		'{1'b1, 4'h4, 32'hFFFF, 32'hA0EF, 2'h0}, '{1'b1, 4'h4, 32'h0, 32'h60, 2'h0},
		'{1'b1, 4'hC, 32'h3, 32'h3, 2'h0}, '{1'b1, 4'h0, 32'hFFFFFFFF, 32'h5, 2'h0},
		'{1'b1, 4'h6, 32'h1, 32'h0, 2'h2}};
	smrd_top #(.STARTUP_CNT(SC), .POWER_UP_DELAY_TIMER_CNT(PC)) u_dut (.*);
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic tmo(input string n);
		errors++;
		$display("CHECK FAILED %s expected answer seen none", n);
		wrap_up();
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		int k;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (k = 0; k < 64; k++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (k == 64) tmo("bvalid");
		// ready left high: a back-to-back call would drive it twice in one step
		resp = s_axi_bresp;
	endtask
	task automatic rd(input logic [3:0] a);
		int k;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (k = 0; k < 64; k++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (k == 64) tmo("rvalid");
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
	endtask
	task automatic wait_run(output int k);
		for (k = 0; k < 40 && run_enable !== 1'b1; k++) @(posedge aclk);
		if (k == 40) tmo("run_enable");
	endtask
	task automatic rst(input logic pw);
		int k;
		int b;
		b = SC + (pw ? PC : 0);
		aresetn <= 1'b0;
		power_up_delay_enable <= pw;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		wait_run(k);
		chk("start-up cycles", 32'h1, 32'(k >= b - 1 && k <= b + 2));
		$display("test reset delay=%0b done", pw);
	endtask
	task automatic bor(input logic [1:0] cfg, input logic e);
		int k;
		brownout_config_enable <= cfg;
		brownout_level_select <= cfg;
		supply_below_bor <= 1'b1;
		repeat (6) @(posedge aclk);
		chk("level out", 32'(cfg), 32'(bor_level_out));
		chk("brown-out reset", 32'(e), 32'(brownout_reset));
		chk("run held", 32'(!e), 32'(run_enable));
		supply_below_bor <= 1'b0;
		@(posedge aclk);
		wait_run(k);
	endtask
	// untripped side first, then only the selected comparator crosses
	task automatic det(input logic [15:0] c, input logic a, input logic [1:0] es, input logic ei);
		logic [15:0] s;
		s = 16'h1 << c[3:0];
		supply_above_tap <= {15{a}};
		ext_detect_above <= a;
		wr(4'h4, {16'h0, c});
		repeat (6) @(posedge aclk);
		rd(4'h8);
		chk("limit out", 32'(c[3:0]), 32'(detect_limit_out));
		chk("detector on", 32'(c[15] && !(c[13] && device_idle)), 32'(detector_on));
		supply_above_tap <= {15{a}} ^ s[14:0];
		ext_detect_above <= a ^ s[15];
		repeat (6) @(posedge aclk);
		chk("irq", 32'(ei), 32'(irq));
		rd(4'h8);
		chk("detect status", 32'(es), rdat);
	endtask
	initial begin
		{aresetn, power_up_delay_enable, supply_below_bor, ext_detect_above, device_idle} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{bandgap_stable, ref_stable} = 2'h3;
		brownout_level_select = 2'h2;
		brownout_config_enable = 2'h1;
		supply_above_tap = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		rst(1'b1);
		rst(1'b0);
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				wr(rows[i].a, rows[i].d);
				chk("write resp", 32'(rows[i].r), 32'(resp));
			end
			rd(rows[i].a);
			chk("read resp", 32'(rows[i].r), 32'(resp));
			chk("read data", rows[i].e, rdat);
		end
		$display("test registers done");
		wr(4'h0, 32'h0);
		for (int c = 0; c < 4; c++) bor(2'(c), c != 0);
		chk("irq", 32'h1, 32'(irq));
		rd(4'h0);
		chk("control flag", 32'h6, rdat);
		rd(4'h8);
		chk("status", 32'h1, rdat);
		rd(4'h8);
		chk("status cleared", 32'h0, rdat);
		chk("irq", 32'h0, 32'(irq));
		wr(4'h0, 32'h1);
		bor(2'h0, 1'b1);
		wr(4'h0, 32'h0);
		rd(4'h0);
		chk("flag cleared", 32'h4, rdat);
		brownout_config_enable <= 2'h1;
		$display("test brown-out done");
		for (int i = 0; i < 16; i++) det(16'h8080 | 16'(i), 1'b0, 2'h2, 1'b1);
		det(16'h8003, 1'b1, 2'h2, 1'b1);
		det(16'h0083, 1'b0, 2'h0, 1'b0);
		device_idle <= 1'b1;
		det(16'hA083, 1'b0, 2'h0, 1'b0);
		det(16'h8083, 1'b0, 2'h2, 1'b1);
		device_idle <= 1'b0;
		{bandgap_stable, ref_stable} <= 2'h0;
		det(16'h8083, 1'b0, 2'h0, 1'b0);
		rd(4'h4);
		chk("detector view", 32'h8083, rdat);
		{bandgap_stable, ref_stable} <= 2'h3;
		wr(4'hC, 32'h1);
		det(16'h8083, 1'b0, 2'h2, 1'b0);
		$display("test detector done");
		wrap_up();
	end
endmodule
bind smrd_top smrd_asserts #(
	.STARTUP_CNT (STARTUP_CNT),
	.POWER_UP_DELAY_TIMER_CNT    (POWER_UP_DELAY_TIMER_CNT)
) u_chk (
	.aclk                   (aclk),
	.aresetn                (aresetn),
	.power_up_delay_enable  (power_up_delay_enable),
	.brownout_level_select  (brownout_level_select),
	.brownout_config_enable (brownout_config_enable),
	.supply_below_bor       (supply_below_bor),
	.bor_level_out          (bor_level_out),
	.run_enable             (run_enable),
	.brownout_reset         (brownout_reset),
	.irq                    (irq),
	.s_axi_awvalid          (s_axi_awvalid),
	.s_axi_arvalid          (s_axi_arvalid)
);
`default_nettype wire
